// File: rtl/board_switch_monitor_and_reset.sv
// Board switch monitor, faceplate reset/abort handling and switch overrides
// Operation
// R1 - Short reset button press gives a reset request, not a hard reset.
// R2 - Reset button held two seconds forces a hard CPU reset.
// R3 - Abort button press raises a non-maskable interrupt request.
// R4 - Monitor bit 0 shows console redirect switch, 1 when closed.
// R5 - Monitor bits 1 and 2 show the two soft config switches.
// R6 - Drive role switch open means master, closed means slave.
// R7 - Closed BIOS flash protect switch blocks writes to BIOS flash region.
// R8 - Monitor bit 7 shows the BIOS flash protect switch.
// R9 - Flash write needs switch permission and flash control write enable bit.
// R10 - Boot source switch open boots main flash, closed boots recovery module.
// R11 - Monitor bit 6 shows the boot source switch.
// R12 - Boot source switch acts only while recovery override bit is zero.
// R13 - Closed management flash switch write-protects the management flash.
// R14 - Video switch open lets BIOS choose front/rear; closed forces rear. Rear is always enabled here; BIOS only sets front.
// R15 - In peripheral mode a closed bus reset switch ignores PCI reset.
// R16 - All switches and buttons synchronised and debounced before use.
// R17 - Monitor reads have no side effects; bits 3 to 5 read zero.
`timescale 1ns/1ps
module board_switch_monitor_and_reset
	import board_switch_pkg::*;
#(
	parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
	parameter int HOLD_LEN     = HOLD_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] io_addr,
	input  wire logic       io_rd,
	input  wire logic       io_wr,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	input  wire logic       reset_button,
	input  wire logic       abort_button,
	input  wire logic       console_redirect_switch,
	input  wire logic       soft_config_switch_a,
	input  wire logic       soft_config_switch_b,
	input  wire logic       drive_role_switch,
	input  wire logic       bios_flash_protect_switch,
	input  wire logic       boot_source_switch,
	input  wire logic       mgmt_flash_protect_switch,
	input  wire logic       video_route_switch,
	input  wire logic       bus_reset_ignore_switch,
	input  wire logic       pci_reset_in_n,
	input  wire logic       peripheral_mode,
	input  wire logic       bios_video_front,
	input  wire logic       flash_write_req,
	input  wire logic       flash_bios_region,
	output logic            cpu_reset_request,
	output logic            cpu_hard_reset,
	output logic            nmi_request,
	output logic            drive_slave,
	output logic            flash_write_strobe,
	output logic            boot_from_recovery,
	output logic            mgmt_flash_write_protect,
	output logic            video_front_en,
	output logic            video_rear_en,
	output logic            board_pci_reset_n
);

	logic [NUM_INPUTS-1:0] raw_in;
	logic [NUM_INPUTS-1:0] sw;
	logic                  pci_rst_sync_a;
	logic                  pci_rst_sync_b;

	button_state_t         btn_state;
	button_state_t         next_btn_state;
	logic [31:0]           hold_count;
	logic [31:0]           next_hold_count;
	logic                  next_cpu_reset_request;
	logic                  next_cpu_hard_reset;
	logic                  abort_prev;
	logic                  next_nmi_request;

	logic [7:0]            flash_control;
	logic [7:0]            next_flash_control;
	logic [7:0]            switch_monitor;
	logic [7:0]            next_io_rdata;

	logic                  next_drive_slave;
	logic                  next_flash_write_strobe;
	logic                  next_boot_from_recovery;
	logic                  next_mgmt_flash_write_protect;
	logic                  next_video_front_en;
	logic                  next_board_pci_reset_n;

	// High on every pin means closed or pressed
	always_comb begin
		raw_in                  = '0;
		raw_in[IN_RESET_BUTTON] = reset_button;
		raw_in[IN_ABORT_BUTTON] = abort_button;
		raw_in[IN_CONSOLE]      = console_redirect_switch;
		raw_in[IN_SOFT_A]       = soft_config_switch_a;
		raw_in[IN_SOFT_B]       = soft_config_switch_b;
		raw_in[IN_DRIVE_ROLE]   = drive_role_switch;
		raw_in[IN_BIOS_PROTECT] = bios_flash_protect_switch;
		raw_in[IN_BOOT_SOURCE]  = boot_source_switch;
		raw_in[IN_MGMT_PROTECT] = mgmt_flash_protect_switch;
		raw_in[IN_VIDEO_ROUTE]  = video_route_switch;
		raw_in[IN_BUS_RST_IGN]  = bus_reset_ignore_switch;
	end

	input_debounce #(
		.WIDTH         (NUM_INPUTS),
		.STABLE_CYCLES (DEBOUNCE_LEN)
	) u_debounce ( // R16
		.clk   (clk),
		.rst_n (rst_n),
		.raw   (raw_in),
		.clean (sw)
	);

	// PCI reset is only synchronised; debouncing would stretch a real reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pci_rst_sync_a <= 1'b0;
			pci_rst_sync_b <= 1'b0;
		end else begin
			pci_rst_sync_a <= pci_reset_in_n;
			pci_rst_sync_b <= pci_rst_sync_a;
		end
	end

	// Reset button: short press requests, long hold forces
	always_comb begin
		next_btn_state         = btn_state;
		next_hold_count        = 32'h0;
		next_cpu_reset_request = 1'b0;
		next_cpu_hard_reset    = 1'b0;
		case (btn_state)
			BTN_IDLE: begin
				if (sw[IN_RESET_BUTTON]) begin
					next_btn_state = BTN_HELD;
				end
			end
			BTN_HELD: begin
				if (!sw[IN_RESET_BUTTON]) begin
					next_btn_state         = BTN_IDLE;
					next_cpu_reset_request = 1'b1; // R1
				end else if (hold_count >= 32'(HOLD_LEN - 2)) begin
					next_btn_state      = BTN_HARD;
					next_cpu_hard_reset = 1'b1; // R2
				end else begin
					next_hold_count = hold_count + 32'h1;
				end
			end
			BTN_HARD: begin
				// Held until release so the release cannot also raise a request
				if (sw[IN_RESET_BUTTON]) begin
					next_cpu_hard_reset = 1'b1; // R2
				end else begin
					next_btn_state = BTN_IDLE;
				end
			end
			default: begin
				next_btn_state = BTN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			btn_state         <= BTN_IDLE;
			hold_count        <= 32'h0;
			cpu_reset_request <= 1'b0;
			cpu_hard_reset    <= 1'b0;
		end else begin
			btn_state         <= next_btn_state;
			hold_count        <= next_hold_count;
			cpu_reset_request <= next_cpu_reset_request;
			cpu_hard_reset    <= next_cpu_hard_reset;
		end
	end

	// Abort button: one pulse per debounced press
	always_comb begin
		next_nmi_request = sw[IN_ABORT_BUTTON] && !abort_prev; // R3
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_prev  <= 1'b0;
			nmi_request <= 1'b0;
		end else begin
			abort_prev  <= sw[IN_ABORT_BUTTON];
			nmi_request <= next_nmi_request;
		end
	end

	// Register file on the I/O port
	always_comb begin
		switch_monitor                      = 8'h00; // R17
		switch_monitor[SM_CONSOLE_BIT]      = sw[IN_CONSOLE]; // R4
		switch_monitor[SM_SOFT_A_BIT]       = sw[IN_SOFT_A]; // R5
		switch_monitor[SM_SOFT_B_BIT]       = sw[IN_SOFT_B]; // R5
		switch_monitor[SM_BOOT_SOURCE_BIT]  = sw[IN_BOOT_SOURCE]; // R11
		switch_monitor[SM_BIOS_PROTECT_BIT] = sw[IN_BIOS_PROTECT]; // R8
	end

	always_comb begin
		next_flash_control = flash_control;
		next_io_rdata      = READ_IDLE_VALUE;
		if (io_wr && io_addr == FLASH_CONTROL_ADDR) begin
			next_flash_control = io_wdata;
		end
		// Reads only select data; no state changes on a read
		if (io_rd) begin
			case (io_addr)
				FLASH_CONTROL_ADDR:  next_io_rdata = flash_control;
				SWITCH_MONITOR_ADDR: next_io_rdata = switch_monitor; // R17
				default:             next_io_rdata = READ_IDLE_VALUE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_control <= FLASH_CONTROL_RESET;
			io_rdata      <= READ_IDLE_VALUE;
		end else begin
			flash_control <= next_flash_control;
			io_rdata      <= next_io_rdata;
		end
	end

	// Switch overrides
	always_comb begin
		next_drive_slave = sw[IN_DRIVE_ROLE]; // R6
		// Only the BIOS region obeys the switch; the enable bit covers all of flash
		next_flash_write_strobe = flash_write_req && flash_control[FC_WRITE_EN_BIT]
			&& !(flash_bios_region && sw[IN_BIOS_PROTECT]); // R7 R9
		next_boot_from_recovery = sw[IN_BOOT_SOURCE]
			&& !flash_control[FC_RECOVERY_OVERRIDE_BIT]; // R10 R12
		next_mgmt_flash_write_protect = sw[IN_MGMT_PROTECT]; // R13
		next_video_front_en = bios_video_front && !sw[IN_VIDEO_ROUTE]; // R14
		next_board_pci_reset_n = pci_rst_sync_b
			|| (peripheral_mode && sw[IN_BUS_RST_IGN]); // R15
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_slave              <= 1'b0;
			flash_write_strobe       <= 1'b0;
			boot_from_recovery       <= 1'b0;
			mgmt_flash_write_protect <= 1'b0;
			video_front_en           <= 1'b0;
			video_rear_en            <= 1'b0;
			board_pci_reset_n        <= 1'b0;
		end else begin
			drive_slave              <= next_drive_slave;
			flash_write_strobe       <= next_flash_write_strobe;
			boot_from_recovery       <= next_boot_from_recovery;
			mgmt_flash_write_protect <= next_mgmt_flash_write_protect;
			video_front_en           <= next_video_front_en;
			video_rear_en            <= 1'b1; // R14
			board_pci_reset_n        <= next_board_pci_reset_n;
		end
	end

	// Checks
	short_press_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
		cpu_reset_request |-> $past(btn_state) == BTN_HELD && !$past(sw[IN_RESET_BUTTON]) && !cpu_hard_reset)
		else $error("reset request without short press");

	hard_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
		$rose(cpu_hard_reset) |-> $past(hold_count) == 32'(HOLD_LEN - 2) && $past(sw[IN_RESET_BUTTON]))
		else $error("hard reset not at hold length");

	hard_release_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
		cpu_hard_reset && !sw[IN_RESET_BUTTON] |=> !cpu_hard_reset ##1 !cpu_reset_request)
		else $error("hard reset outlived button");

	abort_nmi_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
		$rose(sw[IN_ABORT_BUTTON]) |=> nmi_request ##1 !nmi_request)
		else $error("abort press gave no single nmi pulse");

	monitor_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
		io_rd && io_addr == SWITCH_MONITOR_ADDR |=> io_rdata[SM_CONSOLE_BIT] == $past(sw[IN_CONSOLE])
			&& io_rdata[SM_SOFT_B_BIT:SM_SOFT_A_BIT] == $past({sw[IN_SOFT_B], sw[IN_SOFT_A]})
			&& io_rdata[SM_BOOT_SOURCE_BIT] == $past(sw[IN_BOOT_SOURCE])
			&& io_rdata[SM_BIOS_PROTECT_BIT] == $past(sw[IN_BIOS_PROTECT]))
		else $error("switch monitor read mismatch");

	monitor_reserved_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
		io_rd && io_addr == SWITCH_MONITOR_ADDR && !io_wr |=> (io_rdata & SM_RESERVED_MASK) == 8'h00
			&& $stable(flash_control))
		else $error("monitor read reserved bits or side effect");

	flash_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
		flash_write_strobe |-> $past(flash_write_req) && $past(flash_control[FC_WRITE_EN_BIT])
			&& !($past(flash_bios_region) && $past(sw[IN_BIOS_PROTECT])))
		else $error("flash write let through without permission");

	boot_select_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		##1 boot_from_recovery == ($past(sw[IN_BOOT_SOURCE]) && !$past(flash_control[FC_RECOVERY_OVERRIDE_BIT])))
		else $error("boot source selection wrong");

	video_route_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		$past(sw[IN_VIDEO_ROUTE]) |-> !video_front_en && video_rear_en)
		else $error("video front active while forced rear");

	pci_ignore_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
		peripheral_mode && sw[IN_BUS_RST_IGN] |=> board_pci_reset_n)
		else $error("pci reset passed while ignored");

endmodule

// File: include/board_switch_pkg.sv
// Constants for the board switch monitor and faceplate reset logic
package board_switch_pkg;

	// I/O port addresses
	localparam logic [7:0] FLASH_CONTROL_ADDR  = 8'h78;
	localparam logic [7:0] SWITCH_MONITOR_ADDR = 8'he3;

	// Flash control fields
	localparam int         FC_WRITE_EN_BIT          = 1;
	localparam int         FC_RECOVERY_OVERRIDE_BIT = 7;
	localparam logic [7:0] FLASH_CONTROL_RESET      = 8'h00;

	// Switch monitor fields
	localparam int         SM_CONSOLE_BIT       = 0;
	localparam int         SM_SOFT_A_BIT        = 1;
	localparam int         SM_SOFT_B_BIT        = 2;
	localparam int         SM_BOOT_SOURCE_BIT   = 6;
	localparam int         SM_BIOS_PROTECT_BIT  = 7;
	localparam logic [7:0] SM_RESERVED_MASK     = 8'h38;
	localparam logic [7:0] READ_IDLE_VALUE      = 8'h00;

	// Index of each debounced input in the input vector
	localparam int IN_RESET_BUTTON  = 0;
	localparam int IN_ABORT_BUTTON  = 1;
	localparam int IN_CONSOLE       = 2;
	localparam int IN_SOFT_A        = 3;
	localparam int IN_SOFT_B        = 4;
	localparam int IN_DRIVE_ROLE    = 5;
	localparam int IN_BIOS_PROTECT  = 6;
	localparam int IN_BOOT_SOURCE   = 7;
	localparam int IN_MGMT_PROTECT  = 8;
	localparam int IN_VIDEO_ROUTE   = 9;
	localparam int IN_BUS_RST_IGN   = 10;
	localparam int NUM_INPUTS       = 11;

	// Timing
	localparam longint CLK_HZ          = 64'd10000000;
	localparam longint DEBOUNCE_MS     = 64'd10;
	localparam longint HOLD_S          = 64'd2;
	localparam int     DEBOUNCE_CYCLES = int'(CLK_HZ * DEBOUNCE_MS / 64'd1000);
	localparam int     HOLD_CYCLES     = int'(CLK_HZ * HOLD_S);

	// Faceplate reset button sequencing
	typedef enum logic [1:0] {
		BTN_IDLE = 2'b00,
		BTN_HELD = 2'b01,
		BTN_HARD = 2'b10
	} button_state_t;

endpackage

// File: rtl/input_debounce.sv
// Two-flop synchroniser and stability debounce for a vector of pins
`timescale 1ns/1ps
module input_debounce
	import board_switch_pkg::*;
#(
	parameter int WIDTH         = 1,
	parameter int STABLE_CYCLES = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] clean
);

	logic [WIDTH-1:0] sync_a;
	logic [WIDTH-1:0] sync_b;
	logic [WIDTH-1:0] next_clean;
	logic [31:0]      count      [WIDTH];
	logic [31:0]      next_count [WIDTH];

	// Each bit has its own timer so one bouncing contact never delays another
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_clean[i] = clean[i];
			next_count[i] = 32'h0;
			if (sync_b[i] != clean[i]) begin
				if (count[i] >= 32'(STABLE_CYCLES - 1)) begin
					next_clean[i] = sync_b[i];
				end else begin
					next_count[i] = count[i] + 32'h1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= '0;
			sync_b <= '0;
			clean  <= '0;
			for (int i = 0; i < WIDTH; i++) begin
				count[i] <= 32'h0;
			end
		end else begin
			sync_a <= raw;
			sync_b <= sync_a;
			clean  <= next_clean;
			for (int i = 0; i < WIDTH; i++) begin
				count[i] <= next_count[i];
			end
		end
	end

endmodule

// File: tb/pin_model.sv
// Faceplate button and switch bank model with contact chatter
`timescale 1ns/1ps
module pin_model
	import board_switch_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic [NUM_INPUTS-1:0] want,
	output logic      [NUM_INPUTS-1:0] pins
);
	logic [NUM_INPUTS-1:0] p1 = '0;
	logic [NUM_INPUTS-1:0] p2 = '0;
	// Pins settle at the first edge, well inside the reset span
	// One bounce after each change, shorter than any debounce span
	always @(posedge clk) begin
		p1 <= want;
		p2 <= p1;
		pins <= (p1 != p2) ? p2 : want;
	end
endmodule

// File: tb/board_switch_monitor_and_reset_tb_top.sv
// Self-checking bench for the board switch monitor and reset logic
`timescale 1ns/1ps
module board_switch_monitor_and_reset_tb_top
	import board_switch_pkg::*;
;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [7:0]            io_addr = 8'h00;
	logic                  io_rd = 1'b0;
	logic                  io_wr = 1'b0;
	logic [7:0]            io_wdata = 8'h00;
	logic [7:0]            io_rdata;
	logic [NUM_INPUTS-1:0] want = '0;
	logic [NUM_INPUTS-1:0] pins;
	logic                  pci_n = 1'b1;
	logic                  pm = 1'b0;
	logic                  bvf = 1'b0;
	logic                  req = 1'b0;
	logic                  region = 1'b0;
	logic                  rq;
	logic                  hard;
	logic                  nmi;
	logic [6:0]            o;
	int                    err_total = 0;
	int                    cmp_count = 0;
	int                    rq_n = 0;
	int                    nmi_n = 0;
	logic [7:0]            d;
	logic [7:0]            fc;
	logic [7:0]            ex;
	logic [NUM_INPUTS-1:0] w;

	always #50 clk = ~clk;

	pin_model i_pin_model (.clk(clk), .want(want), .pins(pins));

	board_switch_monitor_and_reset #(.DEBOUNCE_LEN(4), .HOLD_LEN(50)) i_board_switch_monitor_and_reset (
		.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
		.io_wdata(io_wdata), .io_rdata(io_rdata),
		.reset_button(pins[IN_RESET_BUTTON]), .abort_button(pins[IN_ABORT_BUTTON]),
		.console_redirect_switch(pins[IN_CONSOLE]), .soft_config_switch_a(pins[IN_SOFT_A]),
		.soft_config_switch_b(pins[IN_SOFT_B]), .drive_role_switch(pins[IN_DRIVE_ROLE]),
		.bios_flash_protect_switch(pins[IN_BIOS_PROTECT]), .boot_source_switch(pins[IN_BOOT_SOURCE]),
		.mgmt_flash_protect_switch(pins[IN_MGMT_PROTECT]), .video_route_switch(pins[IN_VIDEO_ROUTE]),
		.bus_reset_ignore_switch(pins[IN_BUS_RST_IGN]), .pci_reset_in_n(pci_n), .peripheral_mode(pm),
		.bios_video_front(bvf), .flash_write_req(req), .flash_bios_region(region),
		.cpu_reset_request(rq), .cpu_hard_reset(hard), .nmi_request(nmi), .drive_slave(o[0]),
		.flash_write_strobe(o[1]), .boot_from_recovery(o[2]), .mgmt_flash_write_protect(o[3]),
		.video_front_en(o[4]), .video_rear_en(o[5]), .board_pci_reset_n(o[6]));

	// Pulse outputs counted so a double pulse is not missed
	always @(posedge clk) begin
		rq_n <= rq_n + int'(rq === 1'b1);
		nmi_n <= nmi_n + int'(nmi === 1'b1);
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic io_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		io_wr <= 1'b1;
		io_addr <= a;
		io_wdata <= v;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask

	task automatic io_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		io_rd <= 1'b1;
		io_addr <= a;
		@(posedge clk);
		io_rd <= 1'b0;
		#1 v = io_rdata;
	endtask

	task automatic press(input int idx, input int len);
		@(posedge clk);
		want[idx] <= 1'b1;
		repeat (len) @(posedge clk);
		#1 chk("hard_reset_held", {7'h0, len > 60}, {7'h0, hard});
		@(posedge clk);
		want[idx] <= 1'b0;
		repeat (30) @(posedge clk);
		#1 chk("hard_reset_after", 8'h00, {7'h0, hard});
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		// Far longer than the whole sequence, which needs about 610 cycles
		#2000000;
		err_total++;
		test_done();
	end

	initial begin
		void'($urandom(19440));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			w = NUM_INPUTS'($urandom) & ~NUM_INPUTS'(3);
			fc = 8'($urandom);
			@(posedge clk);
			want <= w;
			{pci_n, pm, bvf, region} <= 4'($urandom);
			io_write(FLASH_CONTROL_ADDR, fc);
			io_write(SWITCH_MONITOR_ADDR, ~fc);
			repeat (20) @(posedge clk);
			ex = {w[IN_BIOS_PROTECT], w[IN_BOOT_SOURCE], 3'b000, w[IN_SOFT_B], w[IN_SOFT_A], w[IN_CONSOLE]};
			io_read(SWITCH_MONITOR_ADDR, d);
			chk("monitor", ex, d);
			io_read(SWITCH_MONITOR_ADDR, d);
			chk("monitor_again", ex, d);
			io_read(FLASH_CONTROL_ADDR, d);
			chk("flash_control", fc, d);
			io_read(8'h80, d);
			chk("unmapped", 8'h00, d);
			chk("drive_slave", {7'h0, w[IN_DRIVE_ROLE]}, {7'h0, o[0]});
			chk("boot_recovery", {7'h0, w[IN_BOOT_SOURCE] & ~fc[7]}, {7'h0, o[2]});
			chk("mgmt_protect", {7'h0, w[IN_MGMT_PROTECT]}, {7'h0, o[3]});
			chk("video", {6'h0, 1'b1, bvf & ~w[IN_VIDEO_ROUTE]}, {6'h0, o[5], o[4]});
			chk("pci_reset", {7'h0, pci_n | (pm & w[IN_BUS_RST_IGN])}, {7'h0, o[6]});
			@(posedge clk);
			req <= 1'b1;
			@(posedge clk);
			req <= 1'b0;
			#1 chk("flash_strobe", {7'h0, fc[1] & ~(region & w[IN_BIOS_PROTECT])}, {7'h0, o[1]});
		end
		press(IN_RESET_BUTTON, 15);
		chk("reset_request_short", 8'h01, 8'(rq_n));
		press(IN_RESET_BUTTON, 100);
		chk("reset_request_long", 8'h01, 8'(rq_n));
		press(IN_ABORT_BUTTON, 40);
		chk("nmi_pulses", 8'h01, 8'(nmi_n));
		chk("reset_request_abort", 8'h01, 8'(rq_n));
		test_done();
	end
endmodule
